// ---- design/flash_host_regs.svh ----
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// Avalon register word offsets (byte address = 4 x index)
`define REG_CTRL        4'h0
`define REG_ADDR        4'h1
`define REG_WDATA       4'h2
`define REG_CODE_LO     4'h3
`define REG_CODE_HI     4'h4
`define REG_STAT        4'h5
`define REG_RDATA       4'h6
`define REG_PINS        4'h7

// Control word field positions
`define CTRL_OP_LSB     0
`define CTRL_OP_MSB     3
`define CTRL_GO_BIT     31

// Flash status bit positions
`define SR_READY_BIT    7
`define SR_ESUSP_BIT    6
`define SR_ERASE_ERR    5
`define SR_PROG_ERR     4
`define SR_PROGRAM_ERASE_ENABLE_PIN_ERR     3
`define SR_PSUSP_BIT    2
`define SR_UNLOCK_BIT   0

// Flash command codes
`define CMD_READ_ARRAY  32'h000000FF
`define CMD_READ_STATUS 32'h00000070
`define CMD_CLR_STATUS  32'h00000050
`define CMD_SUSPEND     32'h000000B0
`define CMD_RESUME      32'h000000D0
`define CMD_BCR_SETUP   32'h00000060
`define CMD_BCR_CONFIRM 32'h00000003
`define CMD_UNLOCK      32'h00000078
`define CMD_CODE_PROG   32'h00000048
`define CODE_WORD0      20'h00000
`define CODE_WORD1      20'h00001

// Bus cycle timing
`define T_CYCLE_NS      40
`define CLK_NS          10
`define CYCLE_CNT       ((`T_CYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`define POLL_LIMIT      16'hFFFF

// Reset values
`define CTRL_RST        32'h00000000
`define PINS_RST        2'h3

`endif

// ---- design/flash_host_pkg.sv ----
package flash_host_pkg;

  // Host operations started from the control register
  typedef enum logic [3:0] {
    OP_NONE, OP_WRITE_CMD, OP_READ, OP_SUSPEND, OP_RESUME,
    OP_SET_BCR, OP_UNLOCK, OP_CODE_PROG, OP_READ_ARRAY, OP_CLR_STATUS
  } op_e;

  // Single bus cycle kinds
  typedef enum logic [1:0] {
    CYC_IDLE, CYC_WRITE, CYC_READ
  } cyc_e;

endpackage

// ---- design/flash_bus_cycle.sv ----
`timescale 1ns/1ps
`include "flash_host_regs.svh"

// One asynchronous flash bus cycle, held for a fixed count of clocks
module flash_bus_cycle (
  input  wire logic                 ref_clk_i,  // System clock
  input  wire logic                 nrst_i,     // Async reset, low
  input  wire flash_host_pkg::cyc_e kind_i,     // Cycle request
  input  wire logic [19:0]          addr_i,     // Cycle address
  input  wire logic [31:0]          wdata_i,    // Write data
  output logic                      done_o,     // Cycle finished pulse
  output logic [31:0]               rdata_o,    // Read data captured
  output logic [19:0]               fl_addr_o,  // Flash address
  output logic                      fl_ce_n_o,  // Chip enable, low
  output logic                      fl_oe_n_o,  // Output enable, low
  output logic                      fl_we_n_o,  // Write enable, low
  output logic [31:0]               fl_dq_o,    // Data out
  output logic                      fl_dq_oe_o, // Data drive enable
  input  wire logic [31:0]          fl_dq_i     // Data in
);

  typedef struct packed {
    logic [3:0]  cnt;
    logic        busy;
    logic        wr;
    logic        done;
    logic [19:0] addr;
    logic [31:0] wd;
    logic [31:0] rd;
  } cyc_s;

  cyc_s st_r;
  cyc_s st_nxt;

  // Start on request, hold strobes for the cycle time, then release
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.busy && kind_i != flash_host_pkg::CYC_IDLE)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.wr   = (kind_i == flash_host_pkg::CYC_WRITE);
      st_nxt.addr = addr_i;
      st_nxt.wd   = wdata_i;
      st_nxt.cnt  = 4'(`CYCLE_CNT);
    end
    else if (st_r.busy)
    begin
      if (st_r.cnt == 4'h1)
      begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
        if (!st_r.wr)
          st_nxt.rd = fl_dq_i; // Sample before strobes rise
      end
      st_nxt.cnt = st_r.cnt - 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign done_o     = st_r.done;
  assign rdata_o    = st_r.rd;
  assign fl_addr_o  = st_r.addr;
  assign fl_ce_n_o  = !st_r.busy;
  assign fl_oe_n_o  = !(st_r.busy && !st_r.wr);
  assign fl_we_n_o  = !(st_r.busy && st_r.wr);
  assign fl_dq_o    = st_r.wd;
  assign fl_dq_oe_o = st_r.busy && st_r.wr;

endmodule

// ---- design/flash_host_ctrl.sv ----
`timescale 1ns/1ps
`include "flash_host_regs.svh"

module flash_host_ctrl (
  input  wire logic        ref_clk_i,       // 100 MHz clock
  input  wire logic        nrst_i,          // Async reset, low
  input  wire logic [3:0]  avs_address,     // Word address
  input  wire logic        avs_read,        // Read strobe
  input  wire logic        avs_write,       // Write strobe
  input  wire logic [31:0] avs_writedata,   // Write data
  output logic [31:0]      avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  output logic [19:0]      fl_addr_o,       // Flash address lines
  output logic             fl_ce_n_o,       // Chip enable, low
  output logic             fl_oe_n_o,       // Output enable, low
  output logic             fl_we_n_o,       // Write enable, low
  output logic [31:0]      fl_dq_o,         // Data out
  output logic             fl_dq_oe_o,      // Data drive enable
  input  wire logic [31:0] fl_dq_i,         // Data in
  output logic             program_erase_enable_pin_o, // Enable pin
  output logic             reset_powerdown_pin_n_o     // Reset pin, low
);

  typedef enum logic [3:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_POLL_WAIT, S_DONE
  } seq_e;

  typedef struct packed {
    seq_e                 seq;
    flash_host_pkg::op_e  op;
    logic [2:0]           step;
    logic [19:0]          addr;
    logic [31:0]          wdata;
    logic [31:0]          code_lo;
    logic [31:0]          code_hi;
    logic [7:0]           status;
    logic [31:0]          rdata;
    logic                 busy;
    logic                 err;
    logic                 timeout;
    logic                 suspended;
    logic                 erase_susp;
    logic                 unlocked;
    logic [15:0]          polls;
    logic [1:0]           pins;
    logic                 ack;
    logic [31:0]          rdq;
  } host_s;

  host_s st_r;
  host_s st_nxt;

  flash_host_pkg::cyc_e cyc_kind;
  logic [19:0]          cyc_addr;
  logic [31:0]          cyc_wdata;
  logic                 cyc_done;
  logic [31:0]          cyc_rdata;

  // Fills one word of a multi-write sequence
  function automatic logic [51:0] seq_word(input flash_host_pkg::op_e op,
                                           input logic [2:0] step,
                                           input host_s s);
    logic [19:0] a;
    logic [31:0] d;
    a = 20'h00000;
    d = s.wdata;
    case (op)
      flash_host_pkg::OP_SET_BCR:
      begin
        a = (step == 3'h0) ? 20'h00000 : {4'h0, s.addr[15:0]};
        d = (step == 3'h0) ? `CMD_BCR_SETUP : `CMD_BCR_CONFIRM;
      end
      flash_host_pkg::OP_UNLOCK, flash_host_pkg::OP_CODE_PROG:
      begin
        if (!step[0])
          d = (op == flash_host_pkg::OP_UNLOCK) ? `CMD_UNLOCK
                                                 : `CMD_CODE_PROG;
        else
          d = step[1] ? s.code_hi : s.code_lo;
        a = (step == 3'h3) ? `CODE_WORD1 : `CODE_WORD0;
      end
      default:
      begin
        a = s.addr;
        d = s.wdata;
      end
    endcase
    return {a, d};
  endfunction

  // True when an op may be sent given the tracked device state
  function automatic logic op_allowed(input flash_host_pkg::op_e op,
                                      input host_s s);
    logic ok;
    ok = 1'b1;
    case (op)
      flash_host_pkg::OP_SUSPEND:
        ok = s.busy && !s.suspended;
      flash_host_pkg::OP_RESUME:
        ok = s.suspended;
      flash_host_pkg::OP_CODE_PROG:
        ok = s.unlocked && !s.suspended;
      flash_host_pkg::OP_WRITE_CMD:
        ok = !s.suspended || s.erase_susp;
      flash_host_pkg::OP_SET_BCR, flash_host_pkg::OP_UNLOCK:
        ok = !s.suspended;
      default:
        ok = 1'b1;
    endcase
    return ok;
  endfunction

  // Command sequencer and register file next state
  always_comb
  begin
    logic [51:0] w;
    logic        wr_go;
    w = seq_word(st_r.op, st_r.step, st_r);
    wr_go = avs_write && avs_address == `REG_CTRL
            && avs_writedata[`CTRL_GO_BIT];
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    cyc_kind  = flash_host_pkg::CYC_IDLE;
    cyc_addr  = w[51:32];
    cyc_wdata = w[31:0];

    // Register writes; busy sequencer stalls only control writes via waitrequest
    if (avs_write && !st_r.ack)
    begin
      st_nxt.ack = (st_r.seq == S_IDLE) || avs_address != `REG_CTRL;
      case (avs_address)
        `REG_ADDR:    st_nxt.addr    = avs_writedata[19:0];
        `REG_WDATA:   st_nxt.wdata   = avs_writedata;
        `REG_CODE_LO: st_nxt.code_lo = avs_writedata;
        `REG_CODE_HI: st_nxt.code_hi = avs_writedata;
        `REG_PINS:
        begin
          st_nxt.pins = avs_writedata[1:0];
          if (!avs_writedata[1])
            st_nxt.unlocked = 1'b0;
        end
        default: ;
      endcase
    end
    // Read word is captured on the acking edge so readdata is a flop
    else if (avs_read && !st_r.ack)
    begin
      st_nxt.ack = 1'b1;
      case (avs_address)
        `REG_ADDR:    st_nxt.rdq = {12'h000, st_r.addr};
        `REG_WDATA:   st_nxt.rdq = st_r.wdata;
        `REG_CODE_LO: st_nxt.rdq = st_r.code_lo;
        `REG_CODE_HI: st_nxt.rdq = st_r.code_hi;
        `REG_STAT:    st_nxt.rdq = {16'h0000, st_r.status,
                                    1'b0, st_r.timeout, st_r.err,
                                    st_r.unlocked, st_r.erase_susp,
                                    st_r.suspended, st_r.busy,
                                    st_r.seq != S_IDLE};
        `REG_RDATA:   st_nxt.rdq = st_r.rdata;
        `REG_PINS:    st_nxt.rdq = {30'h0, st_r.pins};
        default:      st_nxt.rdq = 32'h00000000;
      endcase
    end

    case (st_r.seq)
      S_IDLE:
        if (wr_go && !st_r.ack)
        begin
          st_nxt.op = flash_host_pkg::op_e'(
                      avs_writedata[`CTRL_OP_MSB:`CTRL_OP_LSB]);
          st_nxt.step = 3'h0;
          st_nxt.timeout = 1'b0;
          st_nxt.err = !op_allowed(st_nxt.op, st_r);
          if (!st_nxt.err)
            st_nxt.seq = S_ISSUE;
        end
      S_ISSUE:
      begin
        cyc_kind = (st_r.op == flash_host_pkg::OP_READ)
                   ? flash_host_pkg::CYC_READ : flash_host_pkg::CYC_WRITE;
        case (st_r.op)
          flash_host_pkg::OP_SUSPEND:    cyc_wdata = `CMD_SUSPEND;
          flash_host_pkg::OP_RESUME:     cyc_wdata = `CMD_RESUME;
          flash_host_pkg::OP_READ_ARRAY: cyc_wdata = `CMD_READ_ARRAY;
          flash_host_pkg::OP_CLR_STATUS: cyc_wdata = `CMD_CLR_STATUS;
          default: ;
        endcase
        st_nxt.seq = S_WAIT;
      end
      S_WAIT:
        if (cyc_done)
        begin
          st_nxt.seq = S_DONE;
          case (st_r.op)
            flash_host_pkg::OP_READ:
              st_nxt.rdata = cyc_rdata;
            flash_host_pkg::OP_SUSPEND:
              st_nxt.seq = S_POLL;
            flash_host_pkg::OP_RESUME:
            begin
              st_nxt.suspended  = 1'b0;
              st_nxt.erase_susp = 1'b0;
            end
            flash_host_pkg::OP_WRITE_CMD:
              st_nxt.busy = !st_r.suspended;
            flash_host_pkg::OP_READ_ARRAY:
              st_nxt.busy = 1'b0;
            flash_host_pkg::OP_SET_BCR:
              if (st_r.step == 3'h0)
              begin
                st_nxt.step = 3'h1;
                st_nxt.seq  = S_ISSUE;
              end
            flash_host_pkg::OP_UNLOCK, flash_host_pkg::OP_CODE_PROG:
            begin
              st_nxt.step = st_r.step + 3'h1;
              st_nxt.seq = st_r.step[0] ? S_POLL : S_ISSUE;
            end
            default: ;
          endcase
        end
      S_POLL:
      begin
        cyc_kind = flash_host_pkg::CYC_READ;
        st_nxt.seq = S_POLL_WAIT;
      end
      S_POLL_WAIT:
        if (cyc_done)
        begin
          st_nxt.status = cyc_rdata[7:0];
          st_nxt.polls = st_r.polls + 16'h1;
          if (cyc_rdata[`SR_READY_BIT])
          begin
            st_nxt.polls = 16'h0;
            st_nxt.seq = S_DONE;
            if (st_r.op == flash_host_pkg::OP_SUSPEND)
            begin
              st_nxt.suspended  = cyc_rdata[`SR_ESUSP_BIT]
                                  || cyc_rdata[`SR_PSUSP_BIT];
              st_nxt.erase_susp = cyc_rdata[`SR_ESUSP_BIT];
              st_nxt.busy       = st_nxt.suspended;
            end
            else if (st_r.step != 3'h4)
              st_nxt.seq = S_ISSUE;
            else if (st_r.op == flash_host_pkg::OP_UNLOCK)
              st_nxt.unlocked = cyc_rdata[`SR_UNLOCK_BIT];
            if (st_r.step == 3'h4)
              st_nxt.err = cyc_rdata[`SR_PROG_ERR];
          end
          else if (st_r.polls == `POLL_LIMIT)
          begin
            st_nxt.timeout = 1'b1;
            st_nxt.seq = S_DONE;
          end
          else
            st_nxt.seq = S_POLL;
        end
      S_DONE:
        st_nxt.seq = S_IDLE;
      default:
        st_nxt.seq = S_IDLE;
    endcase
    if ((st_r.op == flash_host_pkg::OP_UNLOCK
         || st_r.op == flash_host_pkg::OP_CODE_PROG)
        && st_r.seq != S_IDLE && st_r.pins != 2'h3
        && st_r.seq != S_WAIT && st_r.seq != S_POLL_WAIT)
    begin
      // No strobe may leave once the pins have dropped
      cyc_kind   = flash_host_pkg::CYC_IDLE;
      st_nxt.seq = S_IDLE;
      st_nxt.err = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r      <= '0;
      st_r.pins <= `PINS_RST;
    end
    else
      st_r <= st_nxt;
  end

  // Read data stands from the flop while waitrequest is low
  assign avs_readdata    = st_r.rdq;
  assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
  assign program_erase_enable_pin_o = st_r.pins[0];
  assign reset_powerdown_pin_n_o    = st_r.pins[1];

  flash_bus_cycle u_cycle (
    .ref_clk_i  (ref_clk_i),
    .nrst_i     (nrst_i),
    .kind_i     (cyc_kind),
    .addr_i     (cyc_addr),
    .wdata_i    (cyc_wdata),
    .done_o     (cyc_done),
    .rdata_o    (cyc_rdata),
    .fl_addr_o  (fl_addr_o),
    .fl_ce_n_o  (fl_ce_n_o),
    .fl_oe_n_o  (fl_oe_n_o),
    .fl_we_n_o  (fl_we_n_o),
    .fl_dq_o    (fl_dq_o),
    .fl_dq_oe_o (fl_dq_oe_o),
    .fl_dq_i    (fl_dq_i)
  );

endmodule

// ---- test/flash_dev_model.sv ----
`timescale 1ns/1ps
`include "flash_host_regs.svh"
// Behavioural flash: command decode, status, program suspend, burst
// configuration and the 64-bit code lock. Erase is not modelled.
// with no erase there is no erase suspend to honour
module flash_dev_model #(
  parameter logic [63:0] KEY = 64'h0123_4567_89AB_CDEF // Arbitrary code
) (
  input  wire logic        ref_clk_i, // Clock
  input  wire logic [19:0] addr_i,    // Address lines
  input  wire logic        ce_n_i,    // Chip enable, low
  input  wire logic        oe_n_i,    // Output enable, low
  input  wire logic        we_n_i,    // Write enable, low
  input  wire logic [31:0] dq_i,      // Data from host
  input  wire logic        en_i,      // Program/erase enable
  input  wire logic        rst_n_i,   // Reset/power-down, low
  output logic [31:0]      dq_o       // Data to host
);
  logic [7:0]  sr_r;            // Status bits, bit 7 derived
  logic [31:0] prev_r;          // Pending setup command
  logic [15:0] bcr_r;           // Burst configuration
  logic [63:0] code_r;          // Active code
  logic [63:0] newc_r = KEY;    // Code used after next reset
  logic [31:0] lo_r;            // First code half
  logic [31:0] last_r;          // Last value driven
  logic [31:0] wd_r;            // Write data latched
  logic [19:0] wa_r;            // Write address latched
  logic [7:0]  busy_r;          // Remaining program time
  logic        arr_r;           // Array read mode
  logic        lock_r;          // Tuning blocks locked
  logic        pwr_r = 1'b0;    // Power-up done
  logic        we_q = 1'b1;     // Delayed write strobe
  logic [7:0]  stat;            // Status as read
  logic [31:0] rd_val;          // Read value
  logic [63:0] got;             // Code just entered
  assign stat   = {busy_r == 8'h00 || sr_r[2], sr_r[6:0]};
  assign got    = {wd_r, lo_r};
  // status stays until read array, a burst confirm or reset
  assign rd_val = arr_r ? ({12'h0, addr_i} ^ 32'hA5A5_0000) : {24'h0, stat};
  // Released bus flips, so a stale sample never looks right
  assign dq_o   = (!ce_n_i && !oe_n_i) ? rd_val : ~last_r;
  // Commands act when the write strobe ends
  always @(posedge ref_clk_i)
  begin
    we_q <= we_n_i;
    pwr_r <= 1'b1;
    if (!ce_n_i && !oe_n_i)
      last_r <= rd_val;
    if (!we_n_i)
    begin
      wa_r <= addr_i;
      wd_r <= dq_i;
    end
    // reset locks, loads the new code
    if (!rst_n_i || !pwr_r)
    begin
      sr_r <= 8'h00;
      prev_r <= 32'h0;
      arr_r <= 1'b1;
      lock_r <= 1'b1;
      busy_r <= 8'h00;
      code_r <= newc_r;
      last_r <= 32'h0;
    end
    else if (!we_q && we_n_i)
    begin
      prev_r <= 32'h0;
      if (prev_r == `CMD_BCR_SETUP && wd_r == `CMD_BCR_CONFIRM)
      begin
        bcr_r <= wa_r[15:0];
        arr_r <= 1'b1;
      end
      else if (prev_r == `CMD_BCR_SETUP)
        sr_r[5:4] <= 2'b11;
      // code writes abort on low enable
      else if ((prev_r == `CMD_UNLOCK || prev_r == `CMD_CODE_PROG) && !en_i)
        sr_r[3] <= 1'b1;
      else if ((prev_r == `CMD_UNLOCK || prev_r == `CMD_CODE_PROG)
               && wa_r == `CODE_WORD0)
        lo_r <= wd_r;
      // new code only when unlocked, else a failure
      else if (prev_r == `CMD_CODE_PROG)
      begin
        if (lock_r)
          sr_r[4] <= 1'b1;
        else
          newc_r <= got;
      end
      // compare relocks on a wrong code
      else if (prev_r == `CMD_UNLOCK)
      begin
        lock_r <= got != code_r;
        sr_r[0] <= got == code_r;
        sr_r[4] <= sr_r[4] | (got != code_r);
      end
      else if (prev_r == 32'h40)
        busy_r <= 8'hC8;
      else if (busy_r == 8'h00 || sr_r[2])
        case (wd_r)
          `CMD_SUSPEND:    prev_r <= 32'h0;
          `CMD_RESUME:     sr_r[2] <= 1'b0;
          `CMD_CLR_STATUS: sr_r <= sr_r & 8'hC5;
          `CMD_READ_ARRAY: arr_r <= 1'b1;
          default:
          begin
            prev_r <= sr_r[2] ? 32'h0 : wd_r;
            arr_r <= 1'b0;
          end
        endcase
      else if (wd_r == `CMD_SUSPEND)
        sr_r[2] <= 1'b1;
    end
    else if (busy_r != 8'h00 && !sr_r[2])
      busy_r <= busy_r - 8'h01;
  end
endmodule

// ---- test/flash_host_checker.sv ----
`timescale 1ns/1ps
`include "flash_host_regs.svh"
// Port checks on the flash host controller
module flash_host_checker (
  input wire logic        ref_clk_i,                  // Clock
  input wire logic        nrst_i,                     // Reset, low
  input wire logic        avs_read,                   // Read strobe
  input wire logic        avs_waitrequest,            // Stall
  input wire logic [19:0] fl_addr_o,                  // Flash address
  input wire logic        fl_ce_n_o,                  // Chip enable
  input wire logic        fl_oe_n_o,                  // Output enable
  input wire logic        fl_we_n_o,                  // Write enable
  input wire logic [31:0] fl_dq_o,                    // Data out
  input wire logic        fl_dq_oe_o,                 // Drive enable
  input wire logic        program_erase_enable_pin_o, // Enable pin
  input wire logic        reset_powerdown_pin_n_o     // Reset pin
);
  logic [31:0] last_cmd_r; // Previous write's data
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Updated only while writing, so at a new strobe it holds the last one
  always_ff @(posedge ref_clk_i or negedge nrst_i)
    if (!nrst_i)
      last_cmd_r <= 32'h0;
    else if (!fl_we_n_o)
      last_cmd_r <= fl_dq_o;
  sequence wr_pulse_s;
    (!fl_we_n_o && !fl_ce_n_o && fl_dq_oe_o)[*4] ##1 fl_we_n_o;
  endsequence
  sequence rd_pulse_s;
    (!fl_oe_n_o && !fl_ce_n_o && !fl_dq_oe_o)[*4] ##1 fl_oe_n_o;
  endsequence
  wr_strobe_len_a: assert property ($fell(fl_we_n_o) |-> wr_pulse_s)
    else $error("write strobe shape wrong");
  rd_strobe_len_a: assert property ($fell(fl_oe_n_o) |-> rd_pulse_s)
    else $error("read strobe shape wrong");
  no_contention_a: assert property (fl_dq_oe_o |-> fl_oe_n_o)
    else $error("data driven during read");
  write_held_a: assert property (!fl_we_n_o && !$past(fl_we_n_o)
    |-> $stable(fl_addr_o) && $stable(fl_dq_o))
    else $error("write lines moved");
  bcr_confirm_a: assert property ($fell(fl_we_n_o)
    && fl_dq_o == `CMD_BCR_CONFIRM |-> last_cmd_r == `CMD_BCR_SETUP)
    else $error("confirm without setup");
  // code halves at word 0 or 1
  code_addr_a: assert property ($fell(fl_we_n_o)
    && (last_cmd_r == `CMD_UNLOCK || last_cmd_r == `CMD_CODE_PROG)
    |-> fl_addr_o == `CODE_WORD0 || fl_addr_o == `CODE_WORD1)
    else $error("code half at wrong address");
  // no unlock or code-program command word written with pins down
  code_pins_a: assert property ($fell(fl_we_n_o)
    && (fl_dq_o == `CMD_UNLOCK || fl_dq_o == `CMD_CODE_PROG)
    |-> program_erase_enable_pin_o && reset_powerdown_pin_n_o)
    else $error("code sequence with pins low");
  read_ack_a: assert property ($rose(avs_read) |=> !avs_waitrequest)
    else $error("read not answered");
endmodule

bind flash_host_ctrl flash_host_checker u_chk (
  .ref_clk_i                  (ref_clk_i),
  .nrst_i                     (nrst_i),
  .avs_read                   (avs_read),
  .avs_waitrequest            (avs_waitrequest),
  .fl_addr_o                  (fl_addr_o),
  .fl_ce_n_o                  (fl_ce_n_o),
  .fl_oe_n_o                  (fl_oe_n_o),
  .fl_we_n_o                  (fl_we_n_o),
  .fl_dq_o                    (fl_dq_o),
  .fl_dq_oe_o                 (fl_dq_oe_o),
  .program_erase_enable_pin_o (program_erase_enable_pin_o),
  .reset_powerdown_pin_n_o    (reset_powerdown_pin_n_o)
);

// ---- test/tb.sv ----
`timescale 1ns/1ps
`include "flash_host_regs.svh"
// Register-port bench with a flash model on the far side
module tb;
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF; // Arbitrary
  logic        ref_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, dq_o, dq_i, rq, st, v;
  logic        avs_waitrequest, ce_n, oe_n, we_n, dq_oe, en, rp_n;
  logic [19:0] fl_addr;
  logic [63:0] nk;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          seed = 32'hDAE6;
  int          i;
  always #5 ref_clk_i = ~ref_clk_i;
  flash_host_ctrl u_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fl_addr_o(fl_addr),
    .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n), .fl_dq_o(dq_o),
    .fl_dq_oe_o(dq_oe), .fl_dq_i(dq_i), .program_erase_enable_pin_o(en),
    .reset_powerdown_pin_n_o(rp_n));
  flash_dev_model #(.KEY(KEY)) u_dev (.ref_clk_i(ref_clk_i), .addr_i(fl_addr),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_i(dq_o), .en_i(en),
    .rst_n_i(rp_n), .dq_o(dq_i));
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A hang counts as a mismatch
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  // Start an operation and poll until the sequencer is idle
  task automatic op(input logic [3:0] o, output logic [31:0] s);
    av(1'b1, `REG_CTRL, {1'b1, 27'h0, o}, s);
    s = 32'h1;
    while (s[0] !== 1'b0)
      av(1'b0, `REG_STAT, 32'h0, s);
  endtask
  task automatic code_op(input logic [63:0] c, input logic [3:0] o);
    av(1'b1, `REG_CODE_LO, c[31:0], rq);
    av(1'b1, `REG_CODE_HI, c[63:32], rq);
    op(o, st);
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    av(1'b0, `REG_CTRL, 32'h0, rq);
    chk(rq, `CTRL_RST);
    av(1'b0, `REG_PINS, 32'h0, rq);
    chk(rq, {30'h0, `PINS_RST});
    av(1'b0, 4'hC, 32'h0, rq);
    // Burst value from low lines, all-ones corner first, then reads array
    for (i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      av(1'b1, `REG_ADDR, v, rq);
      op(flash_host_pkg::OP_SET_BCR, st);
      chk(u_dev.bcr_r, v[15:0]);
      op(flash_host_pkg::OP_READ, st);
      av(1'b0, `REG_RDATA, 32'h0, rq);
      chk(rq, {12'h0, v[19:0]} ^ 32'hA5A5_0000);
    end
    code_op(KEY, flash_host_pkg::OP_UNLOCK);
    chk(st[4], 1'b1);
    op(flash_host_pkg::OP_READ_ARRAY, st);
    code_op(KEY ^ {$random(seed), 32'h1}, flash_host_pkg::OP_UNLOCK);
    chk(st[4], 1'b0);
    chk(u_dev.sr_r[4], 1'b1);
    op(flash_host_pkg::OP_CLR_STATUS, st);
    chk(u_dev.sr_r[4], 1'b0);
    op(flash_host_pkg::OP_READ_ARRAY, st);
    code_op(KEY, flash_host_pkg::OP_UNLOCK);
    op(flash_host_pkg::OP_READ_ARRAY, st);
    nk = {$random(seed), $random(seed)};
    code_op(nk, flash_host_pkg::OP_CODE_PROG);
    chk(u_dev.newc_r, nk);
    op(flash_host_pkg::OP_READ_ARRAY, st);
    av(1'b1, `REG_PINS, 32'h1, rq);
    av(1'b1, `REG_PINS, 32'h2, rq);
    chk(u_dev.lock_r, 1'b1);
    code_op(nk, flash_host_pkg::OP_UNLOCK);
    chk(st[4], 1'b0);
    chk(st[5], 1'b1);
    av(1'b1, `REG_PINS, 32'h3, rq);
    op(flash_host_pkg::OP_READ_ARRAY, st);
    code_op(nk, flash_host_pkg::OP_UNLOCK);
    chk(st[4], 1'b1);
    op(flash_host_pkg::OP_READ_ARRAY, st);
    // Program started, suspended mid-way, status read, resumed
    av(1'b1, `REG_WDATA, 32'h40, rq);
    op(flash_host_pkg::OP_WRITE_CMD, st);
    av(1'b1, `REG_WDATA, $random(seed), rq);
    op(flash_host_pkg::OP_WRITE_CMD, st);
    op(flash_host_pkg::OP_SUSPEND, st);
    chk(st[2], 1'b1);
    chk(u_dev.sr_r[2], 1'b1);
    // Program suspend refuses commands outside the allowed set
    op(flash_host_pkg::OP_WRITE_CMD, st);
    chk(st[5], 1'b1);
    op(flash_host_pkg::OP_SET_BCR, st);
    chk(st[5], 1'b1);
    op(flash_host_pkg::OP_READ, st);
    av(1'b0, `REG_RDATA, 32'h0, rq);
    chk(rq, 32'h85);
    op(flash_host_pkg::OP_RESUME, st);
    chk(st[2], 1'b0);
    chk(u_dev.sr_r[2], 1'b0);
    rq = 32'h0;
    while (rq[7] !== 1'b1)
    begin
      op(flash_host_pkg::OP_READ, st);
      av(1'b0, `REG_RDATA, 32'h0, rq);
    end
    op(flash_host_pkg::OP_SUSPEND, st);
    chk(u_dev.sr_r[2], 1'b0);
    stop_test();
  end
endmodule
